// ---- rtl/bpqs_seq.sv ----
// Implementation choices: the register addresses and the strobed register port.
module bpqs_seq #(
  parameter int TICK_CYCLES = bpqs_pkg::BPQS_TICK_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // register port
  input wire bpqs_pkg::bpqs_bus_t i_bus,
  output logic [31:0] o_rdata,
  // pins and measurements
  input wire bpqs_pkg::bpqs_pins_t i_pins,
  input wire logic [15:0] i_vdc,
  input wire logic [15:0] i_vfilter,
  // outputs
  output logic o_precharge_cmd,
  output logic o_precharge_ready,
  output logic o_precharge_allowed,
  output logic o_breaker_close,
  output logic o_breaker_close_pulse,
  output logic o_breaker_open_pulse,
  output logic o_modulate,
  output logic o_fault,
  output logic o_warning,
  output logic o_event_log,
  output logic [15:0] o_filter_vref
);
  import bpqs_pkg::*;

  typedef struct packed {
    bpqs_pins_t p1;
    bpqs_pins_t p2;
    logic [31:0] ctrl;
    logic [7:0] ready_pct;
    logic [7:0] allowed_pct;
    logic [7:0] fb_delay_s;
    logic [7:0] ramp_s;
    logic [7:0] max_energ_s;
    logic [15:0] nom_vdc;
    logic [15:0] nom_vac;
    bpqs_state_t st;
    logic [31:0] presc;
    logic [7:0] fb_secs;
    logic [7:0] en_secs;
    logic [31:0] ramp_acc;
    logic ready_q;
    logic ready_armed;
    logic qs_q;
    logic close_cmd;
    logic cpulse;
    logic opulse;
    logic modulate;
    logic fault;
    logic fb_fault;
    logic en_fault;
    logic qs_fault;
    logic warning;
    logic event_log;
    logic pc_cmd;
    logic pc_ready;
    logic pc_allowed;
    logic [15:0] vref;
    logic [31:0] rdata;
  } bpqs_all_t;

  bpqs_all_t r;
  bpqs_all_t next_r;

  logic [1:0] close_mode;
  logic [1:0] open_mode;
  logic [7:0] qs_resp;
  logic own_mcb;
  logic qs_active;
  logic qs_edge;
  logic ready_rise;
  logic start_cmd;
  logic stop_cmd;
  logic tick;
  logic interlocks;
  logic open_req;
  logic close_req;
  logic fb_mismatch;
  logic [23:0] vdc_pct;
  logic [23:0] ready_lvl;
  logic [23:0] allowed_lvl;
  logic [31:0] ramp_step;
  logic [31:0] ramp_sum;

  always_comb begin
    close_mode = r.ctrl[BPQS_CTRL_CLOSE_MODE_LSB +: 2];
    open_mode = r.ctrl[BPQS_CTRL_OPEN_MODE_LSB +: 2];
    qs_resp = r.ctrl[BPQS_CTRL_QS_RESP_LSB +: 8];
    own_mcb = r.ctrl[BPQS_CTRL_OWN_MCB_BIT];
    // compare vdc*100 against pct*nominal to avoid a divider
    vdc_pct = 24'(i_vdc) * 24'd100;
    ready_lvl = 24'(r.ready_pct) * 24'(r.nom_vdc);
    allowed_lvl = 24'(r.allowed_pct) * 24'(r.nom_vdc);
    tick = (r.presc == 32'(TICK_CYCLES - 1));
    qs_active = (r.ctrl[BPQS_CTRL_QS1_EN_BIT] && !r.p2.qs1_n)
      || (r.ctrl[BPQS_CTRL_QS2_EN_BIT] && !r.p2.qs2_n);
    qs_edge = qs_active && !r.qs_q;
    ready_rise = r.pc_ready && !r.ready_q;
    start_cmd = i_bus.wr && i_bus.addr == BPQS_REG_CTRL && i_bus.wdata[BPQS_CTRL_START_BIT];
    stop_cmd = i_bus.wr && i_bus.addr == BPQS_REG_CTRL && i_bus.wdata[BPQS_CTRL_STOP_BIT];
    interlocks = r.p2.run_enable && r.p2.switch_on_enable && r.p2.close_enable && !qs_active;
    open_req = !r.pc_ready
      || (open_mode[0] && stop_cmd)
      || (open_mode[1] && r.fault);
    if (own_mcb && qs_active) begin
      open_req = 1'b1;
    end
    if (!r.p2.close_enable || !r.p2.switch_on_enable) begin
      open_req = 1'b1;
    end
    unique case (close_mode)
      2'd0: close_req = ready_rise && r.ready_armed;
      2'd1: close_req = start_cmd;
      2'd2: close_req = (ready_rise && r.ready_armed) || start_cmd;
      2'd3: close_req = 1'b0;
    endcase
    fb_mismatch = r.close_cmd ? !r.p2.fb_closed : !r.p2.fb_open;
    ramp_step = (32'(r.nom_vac) << 16) / 32'((r.ramp_s == 8'h00) ? 8'h01 : r.ramp_s);
    ramp_sum = r.ramp_acc + (ramp_step / 32'(TICK_CYCLES));
  end

  always_comb begin
    next_r = r;
    next_r.p1 = i_pins;
    next_r.p2 = r.p1;
    next_r.cpulse = 1'b0;
    next_r.opulse = 1'b0;
    next_r.event_log = 1'b0;
    next_r.presc = tick ? 32'h0000_0000 : r.presc + 32'h0000_0001;
    next_r.qs_q = qs_active;
    next_r.ready_q = r.pc_ready;
    next_r.pc_ready = vdc_pct > ready_lvl;
    next_r.pc_allowed = vdc_pct < allowed_lvl;
    next_r.pc_cmd = r.p2.precharge_request;
    // ready must fall before another mode 0 close
    if (!r.pc_ready) begin
      next_r.ready_armed = 1'b1;
    end
    if (qs_edge) begin
      unique case (qs_resp)
        BPQS_QS_INFO: next_r.event_log = 1'b1;
        BPQS_QS_WARN: next_r.warning = 1'b1;
        BPQS_QS_FAULT, BPQS_QS_FAULT_OPEN: next_r.qs_fault = 1'b1;
        default: next_r.warning = r.warning;
      endcase
    end
    if (fb_mismatch) begin
      if (tick && r.fb_secs != 8'hff) begin
        next_r.fb_secs = r.fb_secs + 8'h01;
      end
      if (r.fb_secs > r.fb_delay_s) begin
        next_r.fb_fault = 1'b1;
      end
    end else begin
      next_r.fb_secs = 8'h00;
    end
    if (r.p2.fb_tripped && r.close_cmd) begin
      next_r.fb_fault = 1'b1;
    end
    // fault reset keeps set priority: new events this cycle still latch
    if (i_bus.wr && i_bus.addr == BPQS_REG_CTRL && i_bus.wdata[BPQS_CTRL_FAULT_RESET_BIT]) begin
      next_r.warning = qs_edge && qs_resp == BPQS_QS_WARN;
      next_r.qs_fault = qs_edge && (qs_resp == BPQS_QS_FAULT || qs_resp == BPQS_QS_FAULT_OPEN);
      next_r.fb_fault = (fb_mismatch && r.fb_secs > r.fb_delay_s)
        || (r.p2.fb_tripped && r.close_cmd);
      next_r.en_fault = 1'b0;
    end
    next_r.fault = next_r.qs_fault || next_r.fb_fault || next_r.en_fault;
    unique case (r.st)
      BPQS_ST_IDLE: begin
        next_r.modulate = 1'b0;
        if (close_mode == 2'd3 && r.pc_ready && !r.fault && r.p2.close_enable
            && r.p2.switch_on_enable && !qs_active && own_mcb) begin
          next_r.st = BPQS_ST_ENERGIZE;
          next_r.ramp_acc = 32'h0000_0000;
          next_r.en_secs = 8'h00;
        end else if (close_req && !r.fault && r.p2.close_enable && r.p2.switch_on_enable
                     && !qs_active && own_mcb) begin
          next_r.st = BPQS_ST_CLOSING;
        end
      end
      BPQS_ST_ENERGIZE: begin
        // needs enabled measurement behind the breaker
        if (!r.ctrl[BPQS_CTRL_VMEAS_EN_BIT] || r.en_secs >= r.max_energ_s) begin
          next_r.en_fault = 1'b1;
          next_r.st = BPQS_ST_FAULT;
        end else if (open_req) begin
          next_r.st = BPQS_ST_IDLE;
        end else if (r.ramp_acc[31:16] >= r.nom_vac
                     && i_vfilter >= r.nom_vac) begin
          next_r.st = BPQS_ST_CLOSING;
        end else begin
          next_r.ramp_acc = (ramp_sum[31:16] >= r.nom_vac) ? {r.nom_vac, 16'h0000} : ramp_sum;
        end
        if (tick) begin
          next_r.en_secs = r.en_secs + 8'h01;
        end
      end
      BPQS_ST_CLOSING: begin
        next_r.close_cmd = 1'b1;
        if (!r.close_cmd) begin
          next_r.cpulse = 1'b1;
          next_r.ready_armed = 1'b0;
        end
        if (open_req) begin
          next_r.st = BPQS_ST_IDLE;
        end else if (r.p2.fb_closed) begin
          next_r.st = BPQS_ST_READY;
        end
      end
      BPQS_ST_READY: begin
        if (open_req) begin
          next_r.st = BPQS_ST_IDLE;
        end else if (start_cmd && interlocks && !r.fault) begin
          next_r.st = BPQS_ST_RUN;
        end
      end
      BPQS_ST_RUN: begin
        next_r.modulate = 1'b1;
        if (open_req) begin
          next_r.st = BPQS_ST_IDLE;
        end else if (!interlocks || stop_cmd || r.fault) begin
          next_r.modulate = 1'b0;
          next_r.st = BPQS_ST_READY;
        end
      end
      BPQS_ST_FAULT: begin
        if (!r.fault) begin
          next_r.st = BPQS_ST_IDLE;
        end
      end
    endcase
    // any move to idle or fault opens the breaker
    if (next_r.st == BPQS_ST_IDLE || next_r.st == BPQS_ST_FAULT) begin
      next_r.modulate = 1'b0;
      next_r.vref = 16'h0000;
      if (r.close_cmd) begin
        next_r.close_cmd = 1'b0;
        next_r.opulse = 1'b1;
      end
    end
    if (next_r.st != BPQS_ST_RUN) begin
      next_r.modulate = 1'b0;
    end
    if (r.st == BPQS_ST_ENERGIZE) begin
      next_r.vref = r.ramp_acc[31:16];
    end
    // register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        BPQS_REG_CTRL: next_r.ctrl = {16'h0000, i_bus.wdata[15:0]};
        BPQS_REG_LEVELS: begin
          next_r.ready_pct = i_bus.wdata[7:0];
          next_r.allowed_pct = i_bus.wdata[15:8];
        end
        BPQS_REG_TIMES: begin
          next_r.fb_delay_s = i_bus.wdata[7:0];
          next_r.ramp_s = i_bus.wdata[15:8];
          next_r.max_energ_s = i_bus.wdata[23:16];
        end
        BPQS_REG_NOMINAL: begin
          next_r.nom_vdc = i_bus.wdata[15:0];
          next_r.nom_vac = i_bus.wdata[31:16];
        end
        default: next_r.ctrl = r.ctrl;
      endcase
    end
    next_r.rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        BPQS_REG_CTRL: next_r.rdata = r.ctrl;
        BPQS_REG_LEVELS: next_r.rdata = {16'h0000, r.allowed_pct, r.ready_pct};
        BPQS_REG_TIMES: next_r.rdata = {8'h00, r.max_energ_s, r.ramp_s, r.fb_delay_s};
        BPQS_REG_NOMINAL: next_r.rdata = {r.nom_vac, r.nom_vdc};
        BPQS_REG_STATUS: next_r.rdata = {22'h000000, qs_active, r.close_cmd, r.modulate,
                                         r.pc_allowed, r.pc_ready, 2'b00, r.st};
        BPQS_REG_FLAGS: next_r.rdata = {27'h0000000, r.warning, r.qs_fault, r.en_fault,
                                        r.fb_fault, r.fault};
        BPQS_REG_RAMP: next_r.rdata = {16'h0000, r.vref};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      // inactive pins: quick stops released, enables high, breaker open
      r.p1 <= 9'h1f4;
      r.p2 <= 9'h1f4;
      r.ctrl <= BPQS_CTRL_RESET;
      r.ready_pct <= BPQS_READY_PCT_RESET;
      r.allowed_pct <= BPQS_ALLOWED_PCT_RESET;
      r.fb_delay_s <= BPQS_FB_DELAY_S_RESET;
      r.ramp_s <= BPQS_RAMP_S_RESET;
      r.max_energ_s <= BPQS_MAX_ENERG_S_RESET;
      r.nom_vdc <= BPQS_NOM_VDC_RESET;
      r.nom_vac <= BPQS_NOM_VAC_RESET;
      r.st <= BPQS_ST_IDLE;
      r.ready_armed <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_precharge_cmd = r.pc_cmd;
  assign o_precharge_ready = r.pc_ready;
  assign o_precharge_allowed = r.pc_allowed;
  assign o_breaker_close = r.close_cmd;
  assign o_breaker_close_pulse = r.cpulse;
  assign o_breaker_open_pulse = r.opulse;
  assign o_modulate = r.modulate;
  assign o_fault = r.fault;
  assign o_warning = r.warning;
  assign o_event_log = r.event_log;
  assign o_filter_vref = r.vref;
endmodule : bpqs_seq

// ---- rtl/bpqs_pkg.sv ----
package bpqs_pkg;
  // register offsets (word index == byte address / 4)
  localparam logic [7:0] BPQS_REG_CTRL = 8'h00;
  localparam logic [7:0] BPQS_REG_LEVELS = 8'h04;
  localparam logic [7:0] BPQS_REG_TIMES = 8'h08;
  localparam logic [7:0] BPQS_REG_NOMINAL = 8'h0c;
  localparam logic [7:0] BPQS_REG_STATUS = 8'h10;
  localparam logic [7:0] BPQS_REG_FLAGS = 8'h14;
  localparam logic [7:0] BPQS_REG_RAMP = 8'h18;
  // ctrl field positions
  localparam int BPQS_CTRL_QS_RESP_LSB = 0;
  localparam int BPQS_CTRL_CLOSE_MODE_LSB = 8;
  localparam int BPQS_CTRL_OPEN_MODE_LSB = 10;
  localparam int BPQS_CTRL_QS1_EN_BIT = 12;
  localparam int BPQS_CTRL_QS2_EN_BIT = 13;
  localparam int BPQS_CTRL_OWN_MCB_BIT = 14;
  localparam int BPQS_CTRL_VMEAS_EN_BIT = 15;
  localparam int BPQS_CTRL_START_BIT = 16;
  localparam int BPQS_CTRL_STOP_BIT = 17;
  localparam int BPQS_CTRL_FAULT_RESET_BIT = 18;
  // reset values
  localparam logic [31:0] BPQS_CTRL_RESET = 32'h0000_f00a;
  localparam logic [7:0] BPQS_READY_PCT_RESET = 8'h50;
  localparam logic [7:0] BPQS_ALLOWED_PCT_RESET = 8'h1e;
  localparam logic [7:0] BPQS_FB_DELAY_S_RESET = 8'h02;
  localparam logic [7:0] BPQS_RAMP_S_RESET = 8'h02;
  localparam logic [7:0] BPQS_MAX_ENERG_S_RESET = 8'h0a;
  localparam logic [15:0] BPQS_NOM_VDC_RESET = 16'h0320;
  localparam logic [15:0] BPQS_NOM_VAC_RESET = 16'h0190;
  // timing: one second tick
  localparam int BPQS_CLK_HZ = 25000000;
  localparam int BPQS_TICK_S = 1;
  localparam int BPQS_TICK_CYCLES = BPQS_CLK_HZ * BPQS_TICK_S;
  localparam int BPQS_PULSE_CYCLES = 1;
  // quick-stop response codes
  localparam logic [7:0] BPQS_QS_NONE = 8'h00;
  localparam logic [7:0] BPQS_QS_INFO = 8'h01;
  localparam logic [7:0] BPQS_QS_WARN = 8'h03;
  localparam logic [7:0] BPQS_QS_FAULT = 8'h0a;
  localparam logic [7:0] BPQS_QS_FAULT_OPEN = 8'h0b;

  typedef enum logic [2:0] {
    BPQS_ST_IDLE,
    BPQS_ST_ENERGIZE,
    BPQS_ST_CLOSING,
    BPQS_ST_READY,
    BPQS_ST_RUN,
    BPQS_ST_FAULT
  } bpqs_state_t;

  typedef struct packed {
    logic qs1_n;
    logic qs2_n;
    logic run_enable;
    logic switch_on_enable;
    logic close_enable;
    logic fb_closed;
    logic fb_open;
    logic fb_tripped;
    logic precharge_request;
  } bpqs_pins_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bpqs_bus_t;
endpackage : bpqs_pkg

// ---- tb/bpqs_seq_properties.sv ----
module bpqs_seq_properties #(
  parameter int TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // watched inputs
  input wire bpqs_pkg::bpqs_pins_t i_pins,
  input wire logic [15:0] i_vdc,
  // watched outputs
  input wire logic o_precharge_cmd,
  input wire logic o_precharge_ready,
  input wire logic o_precharge_allowed,
  input wire logic o_breaker_close,
  input wire logic o_breaker_close_pulse,
  input wire logic o_breaker_open_pulse,
  input wire logic o_modulate,
  input wire logic o_fault
);
  import bpqs_pkg::*;
  // levels assume the threshold and nominal registers keep their reset values
  localparam int RDY = int'(BPQS_READY_PCT_RESET) * int'(BPQS_NOM_VDC_RESET);
  localparam int ALW = int'(BPQS_ALLOWED_PCT_RESET) * int'(BPQS_NOM_VDC_RESET);
  // two-second delay plus tick phase and synchroniser slack
  localparam int FB_LIM = 5 * TICK_CYCLES + 8;
  logic [15:0] miss_cnt;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      miss_cnt <= 16'h0;
    end else begin
      miss_cnt <= (o_breaker_close && !i_pins.fb_closed) ? miss_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_close_pulse;
    o_breaker_close_pulse ##1 !o_breaker_close_pulse;
  endsequence
  sequence s_open_pulse;
    o_breaker_open_pulse ##1 !o_breaker_open_pulse;
  endsequence
  property p_ready;
    $past(i_resetn) |-> o_precharge_ready == (int'($past(i_vdc)) * 100 > RDY);
  endproperty
  property p_allowed;
    $past(i_resetn) |-> o_precharge_allowed == (int'($past(i_vdc)) * 100 < ALW);
  endproperty
  property p_cmd;
    $stable(i_pins.precharge_request) [*5] |-> o_precharge_cmd == i_pins.precharge_request;
  endproperty
  property p_close_pulse;
    $rose(o_breaker_close) |-> s_close_pulse;
  endproperty
  property p_open_pulse;
    $fell(o_breaker_close) |-> s_open_pulse;
  endproperty
  property p_run_after_close;
    $rose(o_modulate) |-> o_breaker_close && $past(o_breaker_close, 3);
  endproperty
  property p_close_gate;
    !i_pins.close_enable [*6] |-> !$rose(o_breaker_close);
  endproperty
  property p_run_lock;
    !i_pins.run_enable [*6] |-> !o_modulate;
  endproperty
  property p_fb_fault;
    miss_cnt > 16'(FB_LIM) |-> o_fault;
  endproperty
  a_ready: assert property (p_ready) else $error("ready level wrong");
  a_allowed: assert property (p_allowed) else $error("allowed level wrong");
  a_cmd: assert property (p_cmd) else $error("precharge command wrong");
  a_close_pulse: assert property (p_close_pulse) else $error("close pulse wrong");
  a_open_pulse: assert property (p_open_pulse) else $error("open pulse wrong");
  a_run_after_close: assert property (p_run_after_close) else $error("early run");
  a_close_gate: assert property (p_close_gate) else $error("closed while disabled");
  a_run_lock: assert property (p_run_lock) else $error("run without enable");
  a_fb_fault: assert property (p_fb_fault) else $error("feedback fault missing");
endmodule : bpqs_seq_properties

bind bpqs_seq bpqs_seq_properties #(.TICK_CYCLES(TICK_CYCLES)) props_u (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_pins(i_pins), .i_vdc(i_vdc),
  .o_precharge_cmd(o_precharge_cmd), .o_precharge_ready(o_precharge_ready),
  .o_precharge_allowed(o_precharge_allowed), .o_breaker_close(o_breaker_close),
  .o_breaker_close_pulse(o_breaker_close_pulse), .o_breaker_open_pulse(o_breaker_open_pulse),
  .o_modulate(o_modulate), .o_fault(o_fault)
);

// ---- tb/bpqs_breaker_model.sv ----
module bpqs_breaker_model (
  // clock and command
  input wire logic i_core_clk,
  input wire logic i_close,
  // scenario controls
  input wire logic [7:0] i_lat,
  input wire logic i_stuck,
  // auxiliary contacts
  output logic o_fb_closed,
  output logic o_fb_open
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial begin
    cnt = 8'h0;
    o_fb_closed = 1'b0;
  end
  // contacts follow the coil only after the mechanical delay; stuck never moves
  always @(posedge i_core_clk) begin
    if (i_stuck || i_close == o_fb_closed) begin
      cnt <= 8'h0;
    end else if (cnt >= i_lat) begin
      o_fb_closed <= i_close;
      cnt <= 8'h0;
    end else begin
      cnt <= cnt + 8'h1;
    end
  end
  assign o_fb_open = !o_fb_closed;
endmodule : bpqs_breaker_model

// ---- tb/bpqs_seq_tb_top.sv ----
module bpqs_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bpqs_pkg::*;
  localparam int TICK = 20;
  localparam int RDY = int'(BPQS_READY_PCT_RESET) * int'(BPQS_NOM_VDC_RESET);
  localparam int ALW = int'(BPQS_ALLOWED_PCT_RESET) * int'(BPQS_NOM_VDC_RESET);
  logic clk, rstn, qs1, qs2, run_en, cl_en, trip, preq, stuck, rd_q, ev_seen;
  logic fbc, fbo, pc_cmd, pc_rdy, pc_alw, brk, cpul, opul, modu, flt, warn, evt;
  logic [7:0] lat;
  logic [15:0] vdc, vfil, vref, v;
  logic [31:0] seed, r, rdata;
  logic [31:0] exp_q[$];
  logic [15:0] bnd[4] = '{16'h280, 16'h281, 16'hef, 16'hf0};
  logic [7:0] qc[5] = '{8'h00, 8'h01, 8'h0a, 8'h0b, 8'h03};
  int failures, total_checks;
  bpqs_bus_t bus;
  bpqs_pins_t pins;
  assign pins = {qs1, qs2, run_en, 1'b1, cl_en, fbc, fbo, trip, preq};
  bpqs_seq #(.TICK_CYCLES(TICK)) dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_bus(bus),
    .o_rdata(rdata), .i_pins(pins), .i_vdc(vdc), .i_vfilter(vfil), .o_precharge_cmd(pc_cmd),
    .o_precharge_ready(pc_rdy), .o_precharge_allowed(pc_alw), .o_breaker_close(brk),
    .o_breaker_close_pulse(cpul), .o_breaker_open_pulse(opul), .o_modulate(modu),
    .o_fault(flt), .o_warning(warn), .o_event_log(evt), .o_filter_vref(vref));
  bpqs_breaker_model brk_u (.i_core_clk(clk), .i_close(brk), .i_lat(lat), .i_stuck(stuck),
    .o_fb_closed(fbc), .o_fb_open(fbo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic results();
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t level %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) chk_rd(rdata, exp_q.pop_front());
    rd_q <= bus.rd;
    if (evt === 1'b1) ev_seen = 1'b1;
  end
  // for a read, d is the expected word
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '0;
  endtask : acc
  function automatic logic sel(input int s);
    return s == 0 ? brk : s == 1 ? modu : flt;
  endfunction : sel
  task automatic wt(input int s, input logic e);
    int n;
    n = 0;
    while (sel(s) !== e && n < 600) begin
      @(negedge clk);
      n++;
    end
    chk(sel(s), e);
  endtask : wt
  task automatic rst();
    @(posedge clk);
    rstn <= 1'b0;
    vdc <= 16'h64;
    r = $random(seed);
    lat <= {4'h0, r[3:0]};
    {qs1, qs2, run_en, cl_en, trip, preq, stuck} <= 7'b1111000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask : rst
  function automatic logic [15:0] cf(input logic [1:0] cm, om, input logic [7:0] q);
    return {4'hf, om, cm, q};
  endfunction : cf
  task automatic up(input logic [15:0] c);
    rst();
    vdc <= 16'h2bc;
    acc(1'b1, BPQS_REG_CTRL, {16'h1, c});
    wt(0, 1'b1);
    repeat (int'(lat) + 6) @(negedge clk);
    chk(modu, 1'b0);
    acc(1'b1, BPQS_REG_CTRL, {16'h1, c});
    wt(1, 1'b1);
  endtask : up
  initial begin
    seed = 32'h3143;
    {failures, total_checks} = '0;
    {rd_q, ev_seen, rstn, lat, vfil, vdc, bus} = '0;
    {qs1, qs2, run_en, cl_en, trip, preq, stuck} = 7'b1111000;
    rst();
    acc(1'b0, BPQS_REG_CTRL, BPQS_CTRL_RESET);
    acc(1'b0, BPQS_REG_LEVELS, {16'h0, BPQS_ALLOWED_PCT_RESET, BPQS_READY_PCT_RESET});
    acc(1'b0, BPQS_REG_TIMES, {8'h0, BPQS_MAX_ENERG_S_RESET, BPQS_RAMP_S_RESET,
      BPQS_FB_DELAY_S_RESET});
    acc(1'b0, BPQS_REG_NOMINAL, {BPQS_NOM_VAC_RESET, BPQS_NOM_VDC_RESET});
    acc(1'b1, 8'h1c, 32'hffff_ffff);
    acc(1'b0, 8'h1c, 32'h0);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      v = i < 4 ? bnd[i] : {6'h0, r[9:0]};
      @(posedge clk);
      vdc <= v;
      preq <= r[10];
      @(posedge clk);
      @(negedge clk);
      chk(pc_rdy, int'(v) * 100 > RDY);
      chk(pc_alw, int'(v) * 100 < ALW);
    end
    @(posedge clk);
    preq <= 1'b1;
    repeat (6) @(negedge clk);
    chk(pc_cmd, 1'b1);
    rst();
    vdc <= 16'h2bc;
    wt(0, 1'b1);
    @(posedge clk);
    vdc <= 16'h64;
    wt(0, 1'b0);
    foreach (qc[i]) begin
      up(cf(2'(1 + i % 2), 2'h0, qc[i]));
      ev_seen = 1'b0;
      @(posedge clk);
      if (i % 2) qs2 <= 1'b0;
      else qs1 <= 1'b0;
      wt(0, 1'b0);
      repeat (4) @(negedge clk);
      chk(modu, 1'b0);
      chk(flt, qc[i] >= 8'h0a);
      chk(ev_seen, qc[i] == 8'h01);
      chk(warn, qc[i] == 8'h03);
    end
    for (int k = 0; k < 2; k++) begin
      up(cf(2'h1, 2'h0, 8'h0));
      @(posedge clk);
      if (k) cl_en <= 1'b0;
      else run_en <= 1'b0;
      wt(1, 1'b0);
      if (k) wt(0, 1'b0);
    end
    for (int m = 0; m < 4; m++) begin
      up(cf(2'h1, 2'(m), 8'h0));
      if (m == 2) begin
        @(posedge clk);
        trip <= 1'b1;
      end else acc(1'b1, BPQS_REG_CTRL, {16'h2, cf(2'h1, 2'(m), 8'h0)});
      repeat (12) @(negedge clk);
      chk(brk, m == 0);
    end
    rst();
    stuck <= 1'b1;
    vdc <= 16'h2bc;
    acc(1'b1, BPQS_REG_CTRL, {16'h1, cf(2'h1, 2'h0, 8'h0)});
    wt(0, 1'b1);
    repeat (TICK) @(negedge clk);
    chk(flt, 1'b0);
    wt(2, 1'b1);
    for (int j = 0; j < 2; j++) begin
      rst();
      vfil <= j ? BPQS_NOM_VAC_RESET : 16'h0;
      acc(1'b1, BPQS_REG_CTRL, {16'h1, cf(2'h3, 2'h0, 8'h0)});
      // raise the link only once mode 3 is stored, else mode 0 closes first
      vdc <= 16'h2bc;
      if (j) wt(0, 1'b1);
      else begin
        repeat (3 * TICK) @(negedge clk);
        chk(vref === BPQS_NOM_VAC_RESET, 1'b1);
        wt(2, 1'b1);
        chk(brk, 1'b0);
      end
    end
    results();
  end
  // the whole sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule : bpqs_seq_tb_top
